// ==== verification/fas_operator.sv ====
// Operator model: mode key and push/turn jog switch at the panel.
// Assumes the amplifier clock and MS clocks to one millisecond.
`timescale 1ns/1ps
`default_nettype none
module fas_operator #(
	parameter int unsigned MS = 4
) (
	input wire logic clock_in,
	output logic mode_key_out,
	output logic jog_press_out,
	output logic jog_plus_out,
	output logic jog_minus_out
);
	// Hands off the panel at start
	initial begin
		mode_key_out = 1'b0;
		jog_press_out = 1'b0;
		jog_plus_out = 1'b0;
		jog_minus_out = 1'b0;
	end

	// Hold keys (bit0 mode, bit1 jog) for ms, release, let the panel settle
	task automatic hold(input logic [1:0] keys, input int ms);
		@(posedge clock_in);
		mode_key_out <= keys[0];
		jog_press_out <= keys[1];
		repeat (ms * MS) @(posedge clock_in);
		mode_key_out <= 1'b0;
		jog_press_out <= 1'b0;
		repeat (12) @(posedge clock_in);
	endtask : hold

	// One detent of the jog turn; up picks the plus line
	task automatic turn(input logic up);
		@(posedge clock_in);
		jog_plus_out <= up;
		jog_minus_out <= !up;
		repeat (4) @(posedge clock_in);
		jog_plus_out <= 1'b0;
		jog_minus_out <= 1'b0;
		repeat (8) @(posedge clock_in);
	endtask : turn
endmodule : fas_operator
`default_nettype wire

// ==== verification/fas_setup_checker.sv ====
// Checker of the setup controller: port-level relations over time.
// Assumes it is bound into fas_setup; one clock, reset active low.
`timescale 1ns/1ps
`default_nettype none
module fas_setup_checker
	import fas_pkg::*;
#(
	parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic mode_key_in,
	input wire logic jog_press_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic [13:0] disp_value_out,
	input wire fas_msg_t disp_msg_out,
	input wire logic disp_blink_out,
	input wire logic [4:0] mode_ind_out,
	input wire logic [13:0] threshold_out,
	input wire logic key_locked_out,
	input wire fas_resp_t response_out,
	input wire logic adjust_lock_out
);
	// All checks on the one clock, quiet during reset
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!nrst_in);

	// Mode indicators and threshold range
	AST_MODE_ONEHOT: assert property ($onehot(mode_ind_out))
		else $error("mode indicator not one-hot");
	AST_THRESH_RANGE: assert property (threshold_out <= 14'd9999)
		else $error("threshold above display range");
	// Code decode moves only after a register write
	AST_DECODE_HOLD: assert property (!$past(wr_in) && !$past(wr_in, 2) |->
		$stable(response_out) && $stable(adjust_lock_out))
		else $error("code decode changed without a write");
	AST_ILLEGAL_KEEP: assert property (wr_in && addr_in == ADDR_CODE &&
		wdata_in[15:12] > D1_MAX |=> $stable(response_out) [*2])
		else $error("illegal code was applied");
	AST_DASH_CAUSE: assert property ($rose(disp_msg_out == MSG_DASH) |->
		$past(wr_in) || $past(wr_in, 2))
		else $error("dashes shown without a code write");
	// Key lock toggles only with both keys held, and freezes the mode
	AST_LOCK_BOTH: assert property ($changed(key_locked_out) |->
		$past(mode_key_in, 5) && $past(jog_press_in, 5))
		else $error("key lock changed without both keys held");
	AST_LOCK_FREEZE: assert property (key_locked_out && $past(key_locked_out) |->
		$stable(mode_ind_out))
		else $error("mode changed while keys locked");
	// Captured value holds still while it blinks
	AST_BLINK_HOLD: assert property (disp_blink_out && $past(disp_blink_out) |->
		$stable(disp_value_out))
		else $error("blinking value changed");
endmodule : fas_setup_checker

bind fas_setup fas_setup_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
	.clock_in(clock_in), .nrst_in(nrst_in), .mode_key_in(mode_key_in),
	.jog_press_in(jog_press_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
	.disp_value_out(disp_value_out), .disp_msg_out(disp_msg_out),
	.disp_blink_out(disp_blink_out), .mode_ind_out(mode_ind_out),
	.threshold_out(threshold_out), .key_locked_out(key_locked_out),
	.response_out(response_out), .adjust_lock_out(adjust_lock_out)
);
`default_nettype wire

// ==== verification/test_fas_setup_controller.sv ====
// Self-checking bench of the setup controller with an operator model.
// Assumes MS_CYCLES shrunk to 4 clocks per millisecond.
`timescale 1ns/1ps
`default_nettype none
module test_fas_setup_controller
	import fas_pkg::*;
;
	localparam int MS = 4;
	typedef struct packed {
		logic [15:0] code;
		logic [15:0] kept;
	} fas_tb_row_t;
	// Code written, code expected to stay stored
	fas_tb_row_t rows [8] = '{'{16'h1234, 16'h1234}, '{16'h9e00, 16'h1234},
		'{16'h5745, 16'h5745}, '{16'h000f, 16'h5745}, '{16'h8370, 16'h8370},
		'{16'ha000, 16'h8370}, '{16'h9001, 16'h9001}, '{16'h0007, 16'h0007}};
	logic clock_in, nrst_in, mode_key, jog_press, jog_plus, jog_minus, wr, rd;
	logic blink, locked, sensor, dark_on, adj_lock;
	logic [13:0] intensity, disp_value, threshold;
	logic [3:0] addr;
	logic [31:0] wdata, rdata, rv;
	logic [4:0] mode_ind;
	logic [1:0] hyst, dtype;
	fas_msg_t disp_msg;
	fas_resp_t resp;
	int errors, check_count;

	fas_setup #(.MS_CYCLES(MS)) DUT (.clock_in(clock_in), .nrst_in(nrst_in),
		.mode_key_in(mode_key), .jog_press_in(jog_press), .jog_plus_in(jog_plus),
		.jog_minus_in(jog_minus), .intensity_in(intensity), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.disp_value_out(disp_value), .disp_msg_out(disp_msg), .disp_blink_out(blink),
		.mode_ind_out(mode_ind), .threshold_out(threshold), .key_locked_out(locked),
		.sensor_out(sensor), .response_out(resp), .hysteresis_out(hyst),
		.display_type_out(dtype), .dark_on_out(dark_on), .adjust_lock_out(adj_lock));
	fas_operator #(.MS(MS)) op (.clock_in(clock_in), .mode_key_out(mode_key),
		.jog_press_out(jog_press), .jog_plus_out(jog_plus), .jog_minus_out(jog_minus));

	// 50 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end

	// Compare and count
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One-cycle register write
	task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_in);
		wr <= 1'b1;
		addr <= a;
		wdata <= {16'h0000, d};
		@(posedge clock_in);
		wr <= 1'b0;
	endtask : bus_wr

	// One-cycle register read; data taken in the following cycle
	task automatic bus_rd(input logic [3:0] a);
		@(posedge clock_in);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock_in);
		rd <= 1'b0;
		@(negedge clock_in);
		rv = rdata;
	endtask : bus_rd

	// Response class of the first code digit
	function automatic logic [31:0] resp_of(input logic [3:0] d);
		return (d < 4'h3) ? 32'h0 : (d < 4'h6) ? 32'h1 : (d < 4'h9) ? 32'h2 : 32'h3;
	endfunction : resp_of

	// Verdict and end of run
	task automatic finish_test();
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : finish_test

	// Hang guard
	initial begin
		repeat (90000) @(posedge clock_in);
		errors++;
		finish_test();
	end

	// Main sequence
	initial begin
		nrst_in = 1'b0;
		{wr, rd, addr, wdata} = '0;
		intensity = 14'd3000;
		errors = 0;
		check_count = 0;
		repeat (8) @(posedge clock_in);
		nrst_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		// Walk the modes up to advanced settings
		for (int i = 1; i < 5; i++) begin
			op.hold(2'b01, 5);
			chk("mode_ind", 32'(5'b00001 << i), mode_ind);
		end
		// Code table: legal codes decode, illegal ones leave dashes
		foreach (rows[i]) begin
			bus_wr(ADDR_CODE, rows[i].code);
			bus_rd(ADDR_CODE);
			chk("code", {16'h0000, rows[i].kept}, rv);
			if (rows[i].code != rows[i].kept) begin
				chk("msg", MSG_DASH, disp_msg);
				bus_rd(ADDR_STATUS);
				chk("reject", 1, rv[8]);
			end
			chk("resp", resp_of(rows[i].kept[15:12]), resp);
			chk("hyst", 32'(rows[i].kept[15:12] % 4'h3), hyst);
			chk("dtype", rows[i].kept[9:8], dtype);
			chk("dark", rows[i].kept[10], dark_on);
			chk("alock", rows[i].kept[7:4] < 4'h4, adj_lock);
		end
		// Long mode press leaves advanced; code then read-only to the bus
		op.hold(2'b01, 2100);
		chk("mode_ind", 5'b00001, mode_ind);
		bus_wr(ADDR_CODE, 16'h1234);
		bus_rd(ADDR_CODE);
		chk("code", 32'h0007, rv);
		// Full-auto teach with a dip to 200 during sampling
		fork
			op.hold(2'b10, 700);
			begin
				repeat (600 * MS) @(posedge clock_in);
				bus_rd(ADDR_STATUS);
				chk("teach", 1, rv[6:4]);
				intensity <= 14'd200;
				repeat (8) @(posedge clock_in);
				chk("disp", 200, disp_value);
				intensity <= 14'd3000;
			end
		join
		chk("blink", 1, blink);
		chk("disp", 3000, disp_value);
		chk("thresh", 1600, threshold);
		repeat (1500 * MS) @(posedge clock_in);
		chk("msg", MSG_GOOD, disp_msg);
		repeat (1000 * MS) @(posedge clock_in);
		chk("disp", 1600, disp_value);
		repeat (1000 * MS) @(posedge clock_in);
		chk("disp", 3000, disp_value);
		chk("blink", 0, blink);
		// Fine adjust: three up, one down, committed by a press
		op.hold(2'b01, 5);
		chk("mode_ind", 5'b00010, mode_ind);
		for (int i = 0; i < 4; i++) op.turn(i < 3);
		chk("thresh", 1600, threshold);
		op.hold(2'b10, 5);
		chk("thresh", 1602, threshold);
		// Polarity: a minus turn toggles to dark-on, press confirms
		op.hold(2'b01, 5);
		op.turn(1'b0);
		chk("msg", MSG_DON, disp_msg);
		op.hold(2'b10, 5);
		chk("dark", 1, dark_on);
		bus_rd(ADDR_CODE);
		chk("code", 32'h0407, rv);
		// Timer switched on loads a 10 ms off-delay
		op.hold(2'b01, 5);
		chk("mode_ind", 5'b01000, mode_ind);
		chk("msg", MSG_NON, disp_msg);
		op.turn(1'b1);
		chk("disp", 10, disp_value);
		bus_rd(ADDR_CODE);
		chk("code", 32'h0414, rv);
		intensity <= 14'd0;
		repeat (20) @(posedge clock_in);
		chk("sensor", 1, sensor);
		intensity <= 14'd9999;
		repeat (5 * MS) @(posedge clock_in);
		chk("sensor", 1, sensor);
		repeat (10 * MS) @(posedge clock_in);
		chk("sensor", 0, sensor);
		intensity <= 14'd3000;
		// Wrap round to adjust, then lock and unlock the keys there
		for (int i = 0; i < 3; i++) op.hold(2'b01, 5);
		chk("mode_ind", 5'b00010, mode_ind);
		op.hold(2'b11, 2100);
		chk("locked", 1, locked);
		op.hold(2'b01, 5);
		chk("mode_ind", 5'b00010, mode_ind);
		op.hold(2'b11, 2100);
		chk("locked", 0, locked);
		op.hold(2'b01, 5);
		chk("mode_ind", 5'b00100, mode_ind);
		// Reset in mid-run restores the shipped settings
		nrst_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		chk("sensor", 0, sensor);
		chk("mode_ind", 5'b00001, mode_ind);
		chk("thresh", 14'h03e8, threshold);
		nrst_in <= 1'b1;
		repeat (4) @(posedge clock_in);
		bus_rd(ADDR_CODE);
		chk("code", 32'h0007, rv);
		// On-delay of 10 ms set from advanced settings
		for (int i = 0; i < 4; i++) op.hold(2'b01, 5);
		bus_wr(ADDR_CODE, 16'h0024);
		intensity <= 14'd0;
		repeat (20) @(posedge clock_in);
		chk("sensor", 0, sensor);
		intensity <= 14'd3000;
		repeat (5 * MS) @(posedge clock_in);
		chk("sensor", 0, sensor);
		repeat (10 * MS) @(posedge clock_in);
		chk("sensor", 1, sensor);
		bus_rd(4'hc);
		chk("unmapped", 0, rv);
		finish_test();
	end
endmodule : test_fas_setup_controller
`default_nettype wire

// ==== verilog/fas_key.sv ====
// One operator key: pin synchroniser, edge pulses and held time in ms.
// Assumes a 1 ms enable pulse on the same clock and a synchronous reset copy.
`timescale 1ns/1ps
`default_nettype none
module fas_key
	import fas_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic tick_in,
	input wire logic pin_in,
	output fas_key_t key_out
);
	fas_keyst_t st_r;
	fas_keyst_t st_nxt;

	// Two flops, then edge and hold timing on the clean copy
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.prev = st_r.s2;
		if (!st_r.s2) begin
			st_nxt.held_ms = '0;
		end else if (tick_in && (st_r.held_ms != {HELD_W{1'b1}})) begin
			st_nxt.held_ms = st_r.held_ms + 1'b1;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign key_out.level = st_r.s2;
	assign key_out.rise = st_r.s2 & ~st_r.prev;
	assign key_out.fall = ~st_r.s2 & st_r.prev;
	assign key_out.held_ms = st_r.held_ms;
endmodule : fas_key
`default_nettype wire

// ==== verilog/fas_otimer.sv ====
// Output timer: off-delay, on-delay and one-shot shaping of the detect level.
// Assumes a 1 ms enable pulse and a detect level from the same clock.
`timescale 1ns/1ps
`default_nettype none
module fas_otimer
	import fas_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic tick_in,
	input wire logic detect_in,
	input wire fas_tmode_t tmode_in,
	input wire logic [3:0] digit_in,
	output logic out_out
);
	fas_tmrst_t st_r;
	fas_tmrst_t st_nxt;
	logic [12:0] iv;

	assign iv = fas_interval_ms(digit_in);

	// Interval counting in ms per timer mode
	always_comb begin
		st_nxt = st_r;
		st_nxt.det_prev = detect_in;
		unique case (tmode_in)
			TM_NONE: begin
				st_nxt.cnt = '0;
				st_nxt.out = detect_in;
			end
			TM_OFF_DELAY: begin
				if (detect_in) begin
					st_nxt.cnt = iv;
				end else if (tick_in && (st_r.cnt != '0)) begin
					st_nxt.cnt = st_r.cnt - 1'b1;
				end
				st_nxt.out = detect_in | (st_nxt.cnt != '0);
			end
			TM_ON_DELAY: begin
				if (!detect_in) begin
					st_nxt.cnt = '0;
				end else if (tick_in && (st_r.cnt < iv)) begin
					st_nxt.cnt = st_r.cnt + 1'b1;
				end
				st_nxt.out = detect_in & (st_nxt.cnt >= iv);
			end
			TM_ONE_SHOT: begin
				if (detect_in && !st_r.det_prev && (st_r.cnt == '0)) begin
					st_nxt.cnt = iv;
				end else if (tick_in && (st_r.cnt != '0)) begin
					st_nxt.cnt = st_r.cnt - 1'b1;
				end
				st_nxt.out = (st_nxt.cnt != '0);
			end
		endcase
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign out_out = st_r.out;
endmodule : fas_otimer
`default_nettype wire

// ==== verilog/fas_pkg.sv ====
// Shared constants, enumerations, state records and decoders for the
// fiber amplifier setup controller.
// Assumes a single 50 MHz clock and a 1 ms enable made by the top module.
`default_nettype none
package fas_pkg;
	// Clock and base tick
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned TICK_NS = 1000000;
	localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	// Key timings in milliseconds
	localparam int unsigned TEACH_HOLD_MS = 500;
	localparam int unsigned LONG_HOLD_MS = 2000;
	localparam int unsigned PHASE_MS = 1000;
	localparam int unsigned HELD_W = 12;
	// Light intensity range and teach stability margin
	localparam logic [13:0] INTENSITY_MAX = 14'h270f;
	localparam logic [13:0] STABLE_MIN = 14'h0064;
	// Setting code: digit one in the top nibble
	localparam logic [15:0] CODE_RESET = 16'h0007;
	localparam logic [3:0] D1_MAX = 4'h9;
	localparam logic [3:0] D2_MAX = 4'h7;
	localparam logic [3:0] D3_MAX = 4'h7;
	localparam logic [3:0] D4_MAX = 4'he;
	localparam logic [3:0] D4_10MS = 4'h4;
	localparam logic [13:0] THRESH_RESET = 14'h03e8;
	// Register offsets
	localparam logic [3:0] ADDR_CODE = 4'h0;
	localparam logic [3:0] ADDR_THRESH = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;

	typedef enum logic [2:0] {
		MODE_TEACH = 3'b000, MODE_ADJUST = 3'b001, MODE_POLARITY = 3'b010,
		MODE_TIMER = 3'b011, MODE_ADVANCED = 3'b100
	} fas_mode_t;
	typedef enum logic [2:0] {
		TCH_IDLE = 3'b000, TCH_SAMPLE = 3'b001, TCH_ACCEPT = 3'b010,
		TCH_JUDGE = 3'b011, TCH_SHOW = 3'b100
	} fas_teach_t;
	typedef enum logic [2:0] {
		MSG_NUM = 3'b000, MSG_AUTO = 3'b001, MSG_GOOD = 3'b010, MSG_NG = 3'b011,
		MSG_DASH = 3'b100, MSG_LON = 3'b101, MSG_DON = 3'b110, MSG_NON = 3'b111
	} fas_msg_t;
	typedef enum logic [1:0] {
		TM_NONE = 2'b00, TM_OFF_DELAY = 2'b01, TM_ON_DELAY = 2'b10, TM_ONE_SHOT = 2'b11
	} fas_tmode_t;
	typedef enum logic [1:0] {
		RESP_STANDARD = 2'b00, RESP_LONG = 2'b01, RESP_HIGH_SPEED = 2'b10, RESP_SPECIAL = 2'b11
	} fas_resp_t;

	typedef struct packed {
		logic level;
		logic rise;
		logic fall;
		logic [HELD_W-1:0] held_ms;
	} fas_key_t;
	typedef struct packed {
		logic s1;
		logic s2;
		logic prev;
		logic [HELD_W-1:0] held_ms;
	} fas_keyst_t;
	typedef struct packed {
		logic out;
		logic det_prev;
		logic [12:0] cnt;
	} fas_tmrst_t;

	// Interval digit to milliseconds; zero means timer off
	function automatic logic [12:0] fas_interval_ms(input logic [3:0] digit);
		case (digit)
			4'h1: fas_interval_ms = 13'd1;
			4'h2: fas_interval_ms = 13'd3;
			4'h3: fas_interval_ms = 13'd5;
			4'h4: fas_interval_ms = 13'd10;
			4'h5: fas_interval_ms = 13'd30;
			4'h6: fas_interval_ms = 13'd50;
			4'h7: fas_interval_ms = 13'd100;
			4'h8: fas_interval_ms = 13'd300;
			4'h9: fas_interval_ms = 13'd500;
			4'ha: fas_interval_ms = 13'd1000;
			4'hb: fas_interval_ms = 13'd2000;
			4'hc: fas_interval_ms = 13'd3000;
			4'hd: fas_interval_ms = 13'd4000;
			4'he: fas_interval_ms = 13'd5000;
			default: fas_interval_ms = 13'd0;
		endcase
	endfunction : fas_interval_ms

	// A code is legal when every digit stays within its column
	function automatic logic fas_code_ok(input logic [15:0] c);
		fas_code_ok = (c[15:12] <= D1_MAX) && (c[11:8] <= D2_MAX) &&
			(c[7:4] <= D3_MAX) && (c[3:0] <= D4_MAX);
	endfunction : fas_code_ok
endpackage : fas_pkg
`default_nettype wire

// ==== verilog/fas_setup.sv ====
// Front-panel setup and teach controller of a fiber sensor amplifier.
// Assumes raw key pins, an intensity word on this clock, one 50 MHz clock.
// What this block does
// - Jog held half second starts sampling, live
// - Accepted teach blinks; threshold at min/max midpoint
// - Show good or bad stability message after teach
// - Then show threshold, then back to live
// - Adjust mode: turns move threshold, press commits
// - Polarity mode: any turn toggles, press confirms
// - Enabling timer loads off-delay at ten ms
// - Timer off at reset; shows configured interval
// - Off, on-delay, one-shot; fourteen interval digits
// - Decode four-digit code into its settings
// - Illegal code rejected, four dashes shown
// - Setting code resets to 0007
// - Bus code writes only in advanced; long press exits
// - Both keys two seconds lock the keys, except in advanced settings
// - Both keys two seconds again unlock
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fas_setup
	import fas_pkg::*;
#(
	parameter int unsigned MS_CYCLES = TICK_CYCLES
) (
	input wire logic clock_in,
	input wire logic nrst_in,
	input wire logic mode_key_in,
	input wire logic jog_press_in,
	input wire logic jog_plus_in,
	input wire logic jog_minus_in,
	input wire logic [13:0] intensity_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	output logic [13:0] disp_value_out,
	output fas_msg_t disp_msg_out,
	output logic disp_blink_out,
	output logic [4:0] mode_ind_out,
	output logic [13:0] threshold_out,
	output logic key_locked_out,
	output logic sensor_out,
	output fas_resp_t response_out,
	output logic [1:0] hysteresis_out,
	output logic [1:0] display_type_out,
	output logic dark_on_out,
	output logic adjust_lock_out
);
	// Whole controller state, registered in one place
	typedef struct packed {
		logic [15:0] div;
		logic tick;
		fas_mode_t mode;
		logic locked;
		logic combo;
		logic combo_done;
		logic [HELD_W-1:0] combo_ms;
		logic mode_done;
		fas_teach_t teach;
		logic [12:0] phase_ms;
		logic [13:0] smin;
		logic [13:0] smax;
		logic [13:0] thresh;
		logic [13:0] pend_th;
		logic pend_pol;
		logic stable;
		logic [15:0] code;
		logic reject;
		fas_msg_t msg;
		logic [13:0] disp;
		logic blink;
		logic [31:0] rdata;
	} fas_state_t;

	fas_state_t s_r;
	fas_state_t s_nxt;
	logic rst_s1;
	logic rst_n;
	fas_key_t keys [4];
	logic [3:0] pins;
	logic [14:0] mid_sum;
	logic adj_ok;
	logic jog_short;
	logic mode_short;
	logic turn;
	logic detect;

	// Reset: asserted at once, released through two flops
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_s1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n <= rst_s1;
		end
	end

	// Key order: mode, jog press, jog plus, jog minus
	assign pins = {jog_minus_in, jog_plus_in, jog_press_in, mode_key_in};

	// One synchroniser and hold timer per key
	generate
		for (genvar i = 0; i < 4; i++) begin : g_key
			fas_key u_key (
				.clock_in(clock_in),
				.rst_n_in(rst_n),
				.tick_in(s_r.tick),
				.pin_in(pins[i]),
				.key_out(keys[i])
			);
		end
	endgenerate

	// Key events, with two-key combinations kept out of single presses
	assign mode_short = keys[0].fall && !s_r.combo && !s_r.mode_done;
	assign jog_short = keys[1].fall && !s_r.combo && (s_r.teach == TCH_IDLE);
	assign turn = keys[2].rise | keys[3].rise;
	// Turning in adjust mode is allowed under lock only with adjust lock off
	assign adj_ok = !s_r.locked || s_r.code[6];
	assign mid_sum = {1'b0, s_r.smin} + {1'b0, s_r.smax};

	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		s_nxt.rdata = '0;

		// Millisecond enable from the clock divider
		if (s_r.div == 16'(MS_CYCLES - 1)) begin
			s_nxt.div = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.div = s_r.div + 1'b1;
		end

		// Both keys held: count, toggle lock once per hold
		if (keys[0].level && keys[1].level) begin
			s_nxt.combo = 1'b1;
			if (s_r.tick && !s_r.combo_done) begin
				s_nxt.combo_ms = s_r.combo_ms + 1'b1;
			end
			if (!s_r.combo_done && (s_r.combo_ms > HELD_W'(LONG_HOLD_MS))
					&& (s_r.mode != MODE_ADVANCED)) begin
				s_nxt.locked = !s_r.locked;
				s_nxt.combo_done = 1'b1;
			end
		end else begin
			s_nxt.combo_ms = '0;
			s_nxt.combo_done = 1'b0;
			if (!keys[0].level && !keys[1].level) begin
				s_nxt.combo = 1'b0;
			end
		end

		// Long mode press leaves advanced settings for run mode
		if (!keys[0].level) begin
			s_nxt.mode_done = 1'b0;
		end else if (!s_r.combo && (s_r.mode == MODE_ADVANCED)
				&& (keys[0].held_ms >= HELD_W'(LONG_HOLD_MS))) begin
			s_nxt.mode = MODE_TEACH;
			s_nxt.mode_done = 1'b1;
			s_nxt.reject = 1'b0;
		end

		// Short mode press steps through the setting modes
		if (mode_short && !s_r.locked) begin
			unique case (s_r.mode)
				MODE_TEACH: s_nxt.mode = MODE_ADJUST;
				MODE_ADJUST: s_nxt.mode = MODE_POLARITY;
				MODE_POLARITY: s_nxt.mode = MODE_TIMER;
				MODE_TIMER: s_nxt.mode = MODE_ADVANCED;
				MODE_ADVANCED: s_nxt.mode = MODE_TEACH;
				default: s_nxt.mode = MODE_TEACH;
			endcase
			s_nxt.teach = TCH_IDLE;
			s_nxt.pend_th = s_r.thresh;
			s_nxt.pend_pol = s_r.code[10];
			s_nxt.reject = 1'b0;
		end

		// Full-auto teach sequence
		unique case (s_r.teach)
			TCH_IDLE: begin
				if ((s_r.mode == MODE_TEACH) && !s_r.locked && !s_r.combo
						&& keys[1].level && (keys[1].held_ms >= HELD_W'(TEACH_HOLD_MS))) begin
					s_nxt.teach = TCH_SAMPLE;
					s_nxt.smin = intensity_in;
					s_nxt.smax = intensity_in;
				end
			end
			TCH_SAMPLE: begin
				// Track the darkest and brightest readings while held
				if (intensity_in < s_r.smin) begin
					s_nxt.smin = intensity_in;
				end
				if (intensity_in > s_r.smax) begin
					s_nxt.smax = intensity_in;
				end
				if (s_r.combo) begin
					s_nxt.teach = TCH_IDLE;
				end else if (!keys[1].level) begin
					s_nxt.teach = TCH_ACCEPT;
					s_nxt.phase_ms = '0;
					s_nxt.thresh = mid_sum[14:1];
					s_nxt.pend_th = mid_sum[14:1];
					s_nxt.stable = ((s_r.smax - s_r.smin) >= STABLE_MIN);
				end
			end
			TCH_ACCEPT, TCH_JUDGE, TCH_SHOW: begin
				// Each result screen stands for one phase time
				if (s_r.tick) begin
					if (s_r.phase_ms == 13'(PHASE_MS - 1)) begin
						s_nxt.phase_ms = '0;
						unique case (s_r.teach)
							TCH_ACCEPT: s_nxt.teach = TCH_JUDGE;
							TCH_JUDGE: s_nxt.teach = TCH_SHOW;
							default: s_nxt.teach = TCH_IDLE;
						endcase
					end else begin
						s_nxt.phase_ms = s_r.phase_ms + 1'b1;
					end
				end
			end
			default: s_nxt.teach = TCH_IDLE;
		endcase

		// Fine adjustment of the threshold
		if (s_r.mode == MODE_ADJUST) begin
			if (keys[2].rise && adj_ok && (s_r.pend_th < INTENSITY_MAX)) begin
				s_nxt.pend_th = s_r.pend_th + 1'b1;
			end else if (keys[3].rise && adj_ok && (s_r.pend_th != '0)) begin
				s_nxt.pend_th = s_r.pend_th - 1'b1;
			end
			if (jog_short) begin
				s_nxt.thresh = s_r.pend_th;
			end
		end

		// Output polarity selection
		if ((s_r.mode == MODE_POLARITY) && !s_r.locked) begin
			if (turn) begin
				s_nxt.pend_pol = !s_r.pend_pol;
			end
			if (jog_short) begin
				s_nxt.code[10] = s_r.pend_pol;
			end
		end

		// Timer in use or not; enabling loads the 10 ms off-delay
		if ((s_r.mode == MODE_TIMER) && !s_r.locked && turn) begin
			if (s_r.code[5:4] == TM_NONE) begin
				s_nxt.code[5:4] = TM_OFF_DELAY;
				s_nxt.code[3:0] = D4_10MS;
			end else begin
				s_nxt.code[5:4] = TM_NONE;
			end
		end

		// Code writes take effect only in advanced settings
		if (wr_in && (addr_in == ADDR_CODE) && (s_r.mode == MODE_ADVANCED)) begin
			if (fas_code_ok(wdata_in[15:0])) begin
				s_nxt.code = wdata_in[15:0];
				s_nxt.reject = 1'b0;
			end else begin
				s_nxt.reject = 1'b1;
			end
		end

		// Register reads answer in the following cycle
		if (rd_in) begin
			unique case (addr_in)
				ADDR_CODE: s_nxt.rdata = {16'h0000, s_r.code};
				ADDR_THRESH: s_nxt.rdata = {18'h00000, s_r.thresh};
				ADDR_STATUS: s_nxt.rdata = {23'h000000, s_r.reject, s_r.stable,
					s_r.teach, s_r.locked, s_r.mode};
				default: s_nxt.rdata = '0;
			endcase
		end

		// Display contents
		s_nxt.blink = 1'b0;
		s_nxt.msg = MSG_NUM;
		s_nxt.disp = intensity_in;
		if (s_r.reject) begin
			s_nxt.msg = MSG_DASH;
		end else if (s_r.teach == TCH_ACCEPT) begin
			s_nxt.disp = s_r.smax;
			s_nxt.blink = 1'b1;
		end else if (s_r.teach == TCH_JUDGE) begin
			s_nxt.msg = s_r.stable ? MSG_GOOD : MSG_NG;
		end else if (s_r.teach == TCH_SHOW) begin
			s_nxt.disp = s_r.thresh;
		end else if (s_r.mode == MODE_ADJUST) begin
			s_nxt.disp = s_r.pend_th;
		end else if (s_r.mode == MODE_POLARITY) begin
			s_nxt.msg = s_r.pend_pol ? MSG_DON : MSG_LON;
		end else if (s_r.mode == MODE_TIMER) begin
			s_nxt.msg = (s_r.code[5:4] == TM_NONE) ? MSG_NON : MSG_NUM;
			s_nxt.disp = {1'b0, fas_interval_ms(s_r.code[3:0])};
		end
	end

	// State register
	always_ff @(posedge clock_in or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.code <= CODE_RESET;
			s_r.thresh <= THRESH_RESET;
			s_r.pend_th <= THRESH_RESET;
			s_r.mode <= MODE_TEACH;
			s_r.teach <= TCH_IDLE;
			s_r.msg <= MSG_NUM;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Detection against the threshold, inverted for dark-on
	assign detect = (intensity_in >= s_r.thresh) ^ s_r.code[10];

	fas_otimer u_otimer (
		.clock_in(clock_in),
		.rst_n_in(rst_n),
		.tick_in(s_r.tick),
		.detect_in(detect),
		.tmode_in(fas_tmode_t'(s_r.code[5:4])),
		.digit_in(s_r.code[3:0]),
		.out_out(sensor_out)
	);

	// Setting decode from the stored code
	always_comb begin
		unique case (s_r.code[15:12])
			4'h0, 4'h1, 4'h2: response_out = RESP_STANDARD;
			4'h3, 4'h4, 4'h5: response_out = RESP_LONG;
			4'h6, 4'h7, 4'h8: response_out = RESP_HIGH_SPEED;
			default: response_out = RESP_SPECIAL;
		endcase
		unique case (s_r.code[15:12])
			4'h1, 4'h4, 4'h7: hysteresis_out = 2'h1;
			4'h2, 4'h5, 4'h8: hysteresis_out = 2'h2;
			default: hysteresis_out = 2'h0;
		endcase
	end

	assign display_type_out = s_r.code[9:8];
	assign dark_on_out = s_r.code[10];
	assign adjust_lock_out = !s_r.code[6];
	assign rdata_out = s_r.rdata;
	assign disp_value_out = s_r.disp;
	assign disp_msg_out = s_r.msg;
	assign disp_blink_out = s_r.blink;
	assign threshold_out = s_r.thresh;
	assign key_locked_out = s_r.locked;

	// One indicator per setting mode
	always_comb begin
		mode_ind_out = '0;
		mode_ind_out[s_r.mode] = 1'b1;
	end
endmodule : fas_setup
`default_nettype wire
